// ==== hw/cepg_pkg.sv ====
package cepg_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int unsigned SS_TIMEOUT_US  = 1000;
  localparam int unsigned SS_TIMEOUT_CYC = SS_TIMEOUT_US * CYC_PER_US;
  localparam int unsigned DLY_STEP_US    = 500;
  localparam int unsigned DLY_STEP_CYC   = DLY_STEP_US * CYC_PER_US;
  localparam int unsigned OTP_LOAD_CYC   = 64;
  localparam int unsigned RAMP_BASE_CYC  = 16;

  // ==========================================================
  // widths and layout
  localparam int unsigned N_CONV    = 3;
  localparam int unsigned N_BUCK    = 2;
  localparam int unsigned N_PIN     = 3;
  localparam int unsigned SYNC_W    = 5;
  localparam int unsigned CLK_BIT   = 4;
  localparam int unsigned RST_BIT   = 3;
  localparam int unsigned SEL_W     = 2;
  localparam int unsigned DLY_W     = 4;
  localparam int unsigned RATE_W    = 3;
  localparam int unsigned VSET_W    = 8;
  localparam int unsigned BST_W     = 2;
  localparam int unsigned THR_W     = 2;
  localparam int unsigned CNT_W     = 24;
  localparam int unsigned LOAD_W    = 8;
  localparam int unsigned RCNT_W    = 16;

  // ==========================================================
  // codes and reset values
  localparam logic [SEL_W-1:0]  SEL_REG = 2'h0;
  localparam logic [N_PIN-1:0]  PD_RST  = 3'h7;

  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_LOAD    = 2'b01,
    ST_STANDBY = 2'b10,
    ST_ACTIVE  = 2'b11
  } cepg_state_t;

endpackage

// ==== hw/cepg_ramp_if.sv ====
`timescale 1ns/10ps
// ==========================================================
// voltage ramp request and status for one step-down channel
interface cepg_ramp_if;
  logic [cepg_pkg::VSET_W-1:0] target;
  logic [cepg_pkg::RATE_W-1:0] rate;
  logic                        fpwm;
  logic [cepg_pkg::VSET_W-1:0] level;
  logic                        ramping;
  logic                        pwm_forced;
  modport ctl  (output target, rate, fpwm, input level, ramping, pwm_forced);
  modport ramp (input target, rate, fpwm, output level, ramping, pwm_forced);
endinterface // cepg_ramp_if

// ==== hw/cepg_vramp.sv ====
`timescale 1ns/10ps
// ==========================================================
// slew-limited output voltage code
module cepg_vramp (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  cepg_ramp_if.ramp rif
);
  localparam int unsigned RW = cepg_pkg::RCNT_W;
  logic [RW-1:0]                 cnt_reg;
  logic [RW-1:0]                 cnt_next;
  logic [cepg_pkg::VSET_W-1:0]   lvl_reg;
  logic [cepg_pkg::VSET_W-1:0]   lvl_next;
  logic                          busy_reg;
  logic                          frc_reg;

  // one code step per interval, interval doubles with each rate code
  wire [RW-1:0] interval = RW'(cepg_pkg::RAMP_BASE_CYC) << rif.rate;
  wire          moving   = (lvl_reg != rif.target);
  wire          tick     = moving && (cnt_reg >= interval - 1'b1);
  assign cnt_next = (!moving || tick) ? '0 : cnt_reg + 1'b1;
  assign lvl_next = !tick ? lvl_reg :
                    (rif.target > lvl_reg) ? lvl_reg + 1'b1 : lvl_reg - 1'b1; // [RULE_21]

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg  <= '0;
      lvl_reg  <= '0;
      busy_reg <= 1'b0;
      frc_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      lvl_reg  <= lvl_next;
      busy_reg <= (lvl_next != rif.target);
      frc_reg  <= (lvl_next != rif.target) || rif.fpwm; // [RULE_22]
    end
  end
  assign rif.level      = lvl_reg;
  assign rif.ramping    = busy_reg;
  assign rif.pwm_forced = frc_reg;

  ramp_step_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_21]
    $changed(lvl_reg) |-> (lvl_reg - $past(lvl_reg) == 8'h01) ||
                          ($past(lvl_reg) - lvl_reg == 8'h01))
    else $error("voltage code moved by more than one step");
  forced_pwm_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_22]
    busy_reg |-> frc_reg)
    else $error("fixed frequency not forced during a ramp");
endmodule // cepg_vramp

// ==== hw/cepg_conv_chan.sv ====
`timescale 1ns/10ps
// ==========================================================
// enable selection, pin delays and soft-start timeout of one converter
module cepg_conv_chan #(
  parameter int unsigned DLY_STEP_CYC   = cepg_pkg::DLY_STEP_CYC,
  parameter int unsigned SS_TIMEOUT_CYC = cepg_pkg::SS_TIMEOUT_CYC
) (
  input  wire logic                       mclk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       run_i,
  input  wire logic                       on_bit_i,
  input  wire logic [cepg_pkg::SEL_W-1:0] pin_sel_i,
  input  wire logic [cepg_pkg::N_PIN-1:0] pins_i,
  input  wire logic [cepg_pkg::DLY_W-1:0] up_dly_i,
  input  wire logic [cepg_pkg::DLY_W-1:0] dn_dly_i,
  input  wire logic                       ss_done_i,
  input  wire logic                       short_clr_i,
  output logic                            on_o,
  output logic                            slew_o,
  output logic                            short_o
);
  localparam int unsigned CW = cepg_pkg::CNT_W;
  logic [CW-1:0] dly_reg;
  logic [CW-1:0] dly_next;
  logic [CW-1:0] ss_cnt_reg;
  logic          on_reg;
  logic          on_next;
  logic          ss_reg;
  logic          short_reg;
  logic          trip_reg;

  // selected pin and the delay that applies to its new level
  wire          pin_mode  = on_bit_i && (pin_sel_i != cepg_pkg::SEL_REG);
  wire          pin_lvl   = pins_i[pin_sel_i - 2'h1];
  wire          want      = run_i && on_bit_i && (!pin_mode || pin_lvl);
  wire [CW-1:0] dly_len   = CW'((pin_lvl ? up_dly_i : dn_dly_i) * DLY_STEP_CYC);
  wire          ss_expire = on_reg && !ss_reg && (ss_cnt_reg >= CW'(SS_TIMEOUT_CYC - 1));

  // a tripped converter stays off until its request drops once
  always_comb begin
    on_next  = on_reg;
    dly_next = '0;
    if (!run_i || !on_bit_i || trip_reg) begin
      on_next = 1'b0;                                    // [RULE_07] [RULE_08]
    end else if (!pin_mode) begin
      on_next = 1'b1;                                    // [RULE_10]
    end else if (pin_lvl != on_reg) begin
      if (dly_reg >= dly_len) begin
        on_next = pin_lvl;                               // [RULE_09]
      end else begin
        dly_next = dly_reg + 1'b1;
      end
    end
    if (ss_expire) begin
      on_next = 1'b0;                                    // [RULE_12] [RULE_17]
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dly_reg    <= '0;
      ss_cnt_reg <= '0;
      on_reg     <= 1'b0;
      ss_reg     <= 1'b0;
      short_reg  <= 1'b0;
      trip_reg   <= 1'b0;
    end else begin
      dly_reg    <= dly_next;
      ss_cnt_reg <= (on_reg && !ss_reg) ? ss_cnt_reg + 1'b1 : '0;
      on_reg     <= on_next;
      ss_reg     <= on_next && (ss_reg || ss_done_i);    // [RULE_11]
      short_reg  <= ss_expire || (short_reg && !short_clr_i);
      trip_reg   <= ss_expire || (trip_reg && want);
    end
  end
  assign on_o    = on_reg;
  assign slew_o  = ss_reg;
  assign short_o = short_reg;

  short_trip_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_12]
    ss_expire |=> !on_reg && short_reg)
    else $error("converter not shut down after soft-start timeout");
endmodule // cepg_conv_chan

// ==== hw/cepg_seq_top.sv ====
`timescale 1ns/10ps
// What this block does
// RULE_01 - sync option off: detector off, internal RC
// RULE_02 - clock interrupt: standby both edges, active loss
// RULE_03 - reset pin rise starts default load
// RULE_04 - host waits 1.2 ms before bus access
// RULE_05 - after load enter standby, run watchdog
// RULE_06 - converters enable in standby or active
// RULE_07 - step-down on-bit and pin select decide
// RULE_08 - step-up uses same enable scheme
// RULE_09 - pin control waits turn-on/turn-off delays
// RULE_10 - register control switches without delays
// RULE_11 - soft start hands over at 0.35 V
// RULE_12 - step-down short: off after 1 ms
// RULE_13 - step-down good flag on becoming valid
// RULE_14 - method bit picks undervoltage or window
// RULE_15 - flag on invalid too, separate masks
// RULE_16 - step-down valid state always live
// RULE_17 - step-up short: off after 1 ms
// RULE_18 - step-up good flag, same method
// RULE_19 - step-up masks and live valid state
// RULE_20 - pin pull-downs on after reset, switchable
// RULE_21 - voltage changes ramp at chosen rate
// RULE_22 - fixed frequency forced during ramps
// RULE_23 - synchronise pins and clock presence
module cepg_seq_top #(
  parameter int unsigned DLY_STEP_CYC   = cepg_pkg::DLY_STEP_CYC,
  parameter int unsigned SS_TIMEOUT_CYC = cepg_pkg::SS_TIMEOUT_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        active_low_reset_input_n_i,
  input  wire logic        supply_ok_i,
  input  wire logic        enable_pin_one_i,
  input  wire logic        enable_pin_two_i,
  input  wire logic        enable_pin_three_i,
  input  wire logic        ext_sync_en_i,
  input  wire logic        ext_clk_present_i,
  input  wire logic        clk_flag_clr_i,
  input  wire logic [1:0]  step_down_on_bit_i,
  input  wire logic        step_up_on_bit_i,
  input  wire logic [3:0]  step_down_pin_select_i,
  input  wire logic [1:0]  step_up_pin_select_i,
  input  wire logic [7:0]  step_down_turn_on_delay_i,
  input  wire logic [7:0]  step_down_turn_off_delay_i,
  input  wire logic [3:0]  step_up_turn_on_delay_i,
  input  wire logic [3:0]  step_up_turn_off_delay_i,
  input  wire logic [15:0] step_down_voltage_code_i,
  input  wire logic [5:0]  step_down_ramp_rate_i,
  input  wire logic [1:0]  step_down_forced_fixed_freq_i,
  input  wire logic [1:0]  step_up_voltage_code_i,
  input  wire logic [2:0]  soft_start_done_i,
  input  wire logic [2:0]  above_uv_i,
  input  wire logic [2:0]  below_ov_i,
  input  wire logic        validity_method_sel_i,
  input  wire logic [3:0]  step_down_threshold_sel_i,
  input  wire logic [1:0]  step_up_threshold_sel_i,
  input  wire logic [1:0]  step_down_rise_valid_mask_i,
  input  wire logic [1:0]  step_down_fall_invalid_mask_i,
  input  wire logic        step_up_rise_valid_mask_i,
  input  wire logic        step_up_fall_invalid_mask_i,
  input  wire logic [2:0]  good_flag_clr_i,
  input  wire logic [2:0]  short_flag_clr_i,
  input  wire logic [2:0]  pulldown_off_i,
  output logic      [1:0]  dev_state_o,
  output logic             otp_load_o,
  output logic             io_enable_o,
  output logic             watchdog_run_o,
  output logic             clk_det_en_o,
  output logic             use_ext_clk_o,
  output logic             clk_flag_o,
  output logic      [2:0]  conv_on_o,
  output logic      [2:0]  slew_mode_o,
  output logic      [2:0]  short_flag_o,
  output logic      [1:0]  step_down_good_flag_o,
  output logic             step_up_good_flag_o,
  output logic      [1:0]  step_down_valid_state_o,
  output logic             step_up_valid_state_o,
  output logic      [5:0]  threshold_sel_o,
  output logic      [15:0] step_down_target_reg_o,
  output logic      [1:0]  fixed_freq_o,
  output logic      [1:0]  step_up_level_o,
  output logic      [2:0]  enable_pin_pulldown_on_o
);
  localparam int unsigned NC = cepg_pkg::N_CONV;
  localparam int unsigned NB = cepg_pkg::N_BUCK;
  localparam logic [cepg_pkg::LOAD_W-1:0] LOAD_LAST =
    cepg_pkg::LOAD_W'(cepg_pkg::OTP_LOAD_CYC - 1);

  // standby and active are the only states where converters may run
  function automatic logic cepg_is_run(input cepg_pkg::cepg_state_t s);
    return (s == cepg_pkg::ST_STANDBY) || (s == cepg_pkg::ST_ACTIVE);
  endfunction

  // ==========================================================
  // input synchronisers
  logic [cepg_pkg::SYNC_W-1:0] meta_reg;
  logic [cepg_pkg::SYNC_W-1:0] sync_reg;
  wire  [cepg_pkg::SYNC_W-1:0] raw_in = {ext_clk_present_i, active_low_reset_input_n_i,
                                         enable_pin_three_i, enable_pin_two_i,
                                         enable_pin_one_i};

  // meta_reg feeds sync_reg only, nothing else looks at it
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= raw_in;                                // [RULE_23]
      sync_reg <= meta_reg;
    end
  end
  wire [cepg_pkg::N_PIN-1:0] pins_s  = sync_reg[cepg_pkg::N_PIN-1:0];
  wire                       rstn_s  = sync_reg[cepg_pkg::RST_BIT];
  wire                       extck_s = sync_reg[cepg_pkg::CLK_BIT];

  // ==========================================================
  // device state
  cepg_pkg::cepg_state_t       state_reg;
  cepg_pkg::cepg_state_t       state_next;
  logic [cepg_pkg::LOAD_W-1:0] load_cnt_reg;
  logic                        rstn_prev_reg;
  logic [NC-1:0]               conv_on;

  wire rst_rise = rstn_s && !rstn_prev_reg;
  wire run      = cepg_is_run(state_reg);
  wire run_next = cepg_is_run(state_next);

  // loss of supply or a low reset pin always wins over progress
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cepg_pkg::ST_RESET: begin
        if (rst_rise && supply_ok_i) state_next = cepg_pkg::ST_LOAD;   // [RULE_03]
      end
      cepg_pkg::ST_LOAD: begin
        if (load_cnt_reg == LOAD_LAST) state_next = cepg_pkg::ST_STANDBY; // [RULE_05]
      end
      cepg_pkg::ST_STANDBY: begin
        if (|conv_on) state_next = cepg_pkg::ST_ACTIVE;
      end
      cepg_pkg::ST_ACTIVE: begin
        if (!(|conv_on)) state_next = cepg_pkg::ST_STANDBY;
      end
      default: state_next = cepg_pkg::ST_RESET;
    endcase
    if (!rstn_s || !supply_ok_i) state_next = cepg_pkg::ST_RESET;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg      <= cepg_pkg::ST_RESET;
      load_cnt_reg   <= '0;
      rstn_prev_reg  <= 1'b0;
      otp_load_o     <= 1'b0;
      io_enable_o    <= 1'b0;
      watchdog_run_o <= 1'b0;
    end else begin
      state_reg      <= state_next;
      load_cnt_reg   <= (state_reg == cepg_pkg::ST_LOAD) ? load_cnt_reg + 1'b1 : '0;
      rstn_prev_reg  <= rstn_s;
      otp_load_o     <= (state_next == cepg_pkg::ST_LOAD);       // [RULE_03]
      io_enable_o    <= (state_next != cepg_pkg::ST_RESET);      // [RULE_03]
      watchdog_run_o <= run_next;                                // [RULE_05]
    end
  end
  assign dev_state_o = state_reg;

  // ==========================================================
  // switching clock source and clock interrupt
  logic extck_prev_reg;
  wire  ck_lost  = extck_prev_reg && !extck_s;
  wire  ck_back  = !extck_prev_reg && extck_s;
  wire  to_stby  = (state_reg == cepg_pkg::ST_LOAD) && (state_next == cepg_pkg::ST_STANDBY);
  wire  to_actv  = (state_reg == cepg_pkg::ST_STANDBY) && (state_next == cepg_pkg::ST_ACTIVE);
  // active mode reports only a vanishing clock; expected-but-absent on entry too
  wire  clk_ev   = ext_sync_en_i && ((run && ck_lost) ||
                   ((state_reg == cepg_pkg::ST_STANDBY) && ck_back) ||
                   ((to_stby || to_actv) && !extck_s));              // [RULE_02]

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      extck_prev_reg <= 1'b0;
      clk_det_en_o   <= 1'b0;
      use_ext_clk_o  <= 1'b0;
      clk_flag_o     <= 1'b0;
    end else begin
      extck_prev_reg <= extck_s;
      clk_det_en_o   <= ext_sync_en_i && run_next;               // [RULE_01]
      use_ext_clk_o  <= ext_sync_en_i && extck_s;                // [RULE_01]
      clk_flag_o     <= clk_ev || (clk_flag_o && !clk_flag_clr_i);
    end
  end

  // ==========================================================
  // converter channels, index 2 is the step-up converter
  wire [NC-1:0]   on_bits  = {step_up_on_bit_i, step_down_on_bit_i};
  wire [2*NC-1:0] sel_all  = {step_up_pin_select_i, step_down_pin_select_i};
  wire [4*NC-1:0] up_all   = {step_up_turn_on_delay_i, step_down_turn_on_delay_i};
  wire [4*NC-1:0] dn_all   = {step_up_turn_off_delay_i, step_down_turn_off_delay_i};
  wire [NC-1:0]   rise_msk = {step_up_rise_valid_mask_i, step_down_rise_valid_mask_i};
  wire [NC-1:0]   fall_msk = {step_up_fall_invalid_mask_i, step_down_fall_invalid_mask_i};
  logic [NC-1:0]  valid_reg;
  logic [NC-1:0]  good_reg;

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_conv
      // run gates every channel so enabling works in standby or active
      cepg_conv_chan #(
        .DLY_STEP_CYC  (DLY_STEP_CYC),
        .SS_TIMEOUT_CYC(SS_TIMEOUT_CYC)
      ) u_chan (
        .mclk_i     (mclk_i),
        .sys_rst_i  (sys_rst_i),
        .run_i      (run),                                       // [RULE_06]
        .on_bit_i   (on_bits[g]),                                // [RULE_07] [RULE_08]
        .pin_sel_i  (sel_all[2*g +: 2]),
        .pins_i     (pins_s),
        .up_dly_i   (up_all[4*g +: 4]),                          // [RULE_09]
        .dn_dly_i   (dn_all[4*g +: 4]),
        .ss_done_i  (soft_start_done_i[g]),                      // [RULE_11] [RULE_17]
        .short_clr_i(short_flag_clr_i[g]),
        .on_o       (conv_on[g]),
        .slew_o     (slew_mode_o[g]),
        .short_o    (short_flag_o[g])
      );

      // validity by undervoltage alone or by the full window
      wire valid_w = above_uv_i[g] && (!validity_method_sel_i || below_ov_i[g]); // [RULE_14] [RULE_18]
      wire rise_ev = valid_w && !valid_reg[g] && !rise_msk[g];   // [RULE_13] [RULE_15]
      wire fall_ev = !valid_w && valid_reg[g] && !fall_msk[g];   // [RULE_15] [RULE_19]

      always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          valid_reg[g] <= 1'b0;
          good_reg[g]  <= 1'b0;
        end else begin
          valid_reg[g] <= valid_w;                               // [RULE_16] [RULE_19]
          good_reg[g]  <= rise_ev || fall_ev || (good_reg[g] && !good_flag_clr_i[g]);
        end
      end
    end
  endgenerate
  assign conv_on_o               = conv_on;
  assign step_down_good_flag_o   = good_reg[NB-1:0];
  assign step_up_good_flag_o     = good_reg[NB];
  assign step_down_valid_state_o = valid_reg[NB-1:0];
  assign step_up_valid_state_o   = valid_reg[NB];

  // ==========================================================
  // step-down voltage ramps
  cepg_ramp_if rif [NB] ();
  generate
    for (g = 0; g < NB; g++) begin : g_ramp
      assign rif[g].target = step_down_voltage_code_i[8*g +: 8];
      assign rif[g].rate   = step_down_ramp_rate_i[3*g +: 3];   // [RULE_21]
      assign rif[g].fpwm   = step_down_forced_fixed_freq_i[g];
      cepg_vramp u_ramp (
        .mclk_i   (mclk_i),
        .sys_rst_i(sys_rst_i),
        .rif      (rif[g].ramp)
      );
      assign step_down_target_reg_o[8*g +: 8] = rif[g].level;
      assign fixed_freq_o[g]                  = rif[g].pwm_forced; // [RULE_22]
    end
  endgenerate

  // ==========================================================
  // pull-downs, thresholds and step-up code
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      enable_pin_pulldown_on_o <= cepg_pkg::PD_RST;
      threshold_sel_o          <= '0;
      step_up_level_o          <= '0;
    end else begin
      // pull-down settings are honoured only once defaults are loaded; thresholds and step-up code always follow
      enable_pin_pulldown_on_o <= run_next ? ~pulldown_off_i : cepg_pkg::PD_RST; // [RULE_20]
      threshold_sel_o          <= {step_up_threshold_sel_i, step_down_threshold_sel_i};
      step_up_level_o          <= step_up_voltage_code_i;    // [RULE_08]
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  clk_sel_off_a: assert property (!ext_sync_en_i |=> !clk_det_en_o && !use_ext_clk_o) // [RULE_01]
    else $error("clock detector or external clock used with sync off");
  clk_loss_irq_a: assert property (ext_sync_en_i && run && ck_lost |=> clk_flag_o) // [RULE_02]
    else $error("clock loss not flagged");
  active_no_back_a: assert property ((state_reg == cepg_pkg::ST_ACTIVE) && ck_back && // [RULE_02]
    !clk_flag_o |=> !clk_flag_o)
    else $error("clock return flagged in active mode");
  boot_load_a: assert property ((state_reg == cepg_pkg::ST_RESET) && rst_rise && // [RULE_03]
    supply_ok_i && rstn_s |=> otp_load_o && io_enable_o)
    else $error("reset release did not start default load");
  standby_entry_a: assert property ($rose(otp_load_o) ##1 (rstn_s && supply_ok_i)[*8] // [RULE_05]
    |-> ##[0:60] watchdog_run_o)
    else $error("standby not reached after default load");
  reg_off_a: assert property (!step_down_on_bit_i[0] |=> !conv_on_o[0]) // [RULE_07]
    else $error("step-down on with on-bit cleared");
  reg_on_a: assert property (run && $rose(step_down_on_bit_i[0]) && // [RULE_10]
    (step_down_pin_select_i[1:0] == cepg_pkg::SEL_REG) |=> conv_on_o[0])
    else $error("register enable was delayed");
  invalid_state_a: assert property (validity_method_sel_i && !below_ov_i[0] // [RULE_16]
    |=> !step_down_valid_state_o[0])
    else $error("valid state ignores overvoltage in window mode");
  pulldown_rst_a: assert property (!run |-> enable_pin_pulldown_on_o == cepg_pkg::PD_RST) // [RULE_20]
    else $error("pull-down off outside standby or active");

  boost_on_c:   cover property ($rose(conv_on_o[2]));
  clk_irq_c:    cover property ($rose(clk_flag_o));
  active_c:     cover property (state_reg == cepg_pkg::ST_ACTIVE);
  short_c:      cover property ($rose(short_flag_o[0]));
endmodule // cepg_seq_top

// ==== verification/cepg_stage_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// power stage stand-in: soft start passes the hand-over level late
module cepg_stage_model (
  input  wire logic       mclk_i,
  input  wire logic [2:0] on_i,
  input  wire logic [2:0] short_i,
  output logic      [2:0] done_o
);
  logic [2:0] d1_reg;
  logic [2:0] d2_reg;
  // a shorted output never rises, so the timeout must trip
  always_ff @(posedge mclk_i) begin
    d1_reg <= on_i & ~short_i;
    d2_reg <= d1_reg & on_i & ~short_i;
    done_o <= d2_reg & on_i & ~short_i;
  end
endmodule // cepg_stage_model

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  // ==========================================================
  // stimulus, zero at time zero except sys_rst_i and supply_ok_i
  logic mclk_i = 0, sys_rst_i = 1, active_low_reset_input_n_i = 0, supply_ok_i = 1;
  logic enable_pin_one_i = 0, enable_pin_two_i = 0, enable_pin_three_i = 0;
  logic ext_sync_en_i = 0, ext_clk_present_i = 0, clk_flag_clr_i = 0, step_up_on_bit_i = 0;
  logic validity_method_sel_i = 0, step_up_rise_valid_mask_i = 0;
  logic step_up_fall_invalid_mask_i = 0;
  logic [1:0] step_down_on_bit_i = '0, step_up_pin_select_i = '0, step_up_voltage_code_i = '0;
  logic [1:0] step_down_forced_fixed_freq_i = '0, step_up_threshold_sel_i = '0;
  logic [1:0] step_down_rise_valid_mask_i = '0, step_down_fall_invalid_mask_i = '0;
  logic [3:0] step_down_pin_select_i = '0, step_up_turn_on_delay_i = '0;
  logic [3:0] step_up_turn_off_delay_i = '0, step_down_threshold_sel_i = '0;
  logic [7:0] step_down_turn_on_delay_i = '0, step_down_turn_off_delay_i = '0;
  logic [15:0] step_down_voltage_code_i = '0;
  logic [5:0] step_down_ramp_rate_i = '0;
  logic [2:0] above_uv_i = '0, below_ov_i = '0, good_flag_clr_i = '0, short_flag_clr_i = '0;
  logic [2:0] pulldown_off_i = '0, sc = '0, soft_start_done_i, v;
  // ==========================================================
  // observed outputs
  logic [1:0] dev_state_o, step_down_good_flag_o, step_down_valid_state_o, fixed_freq_o;
  logic [1:0] step_up_level_o;
  logic otp_load_o, io_enable_o, watchdog_run_o, clk_det_en_o, use_ext_clk_o, clk_flag_o;
  logic step_up_good_flag_o, step_up_valid_state_o;
  logic [2:0] conv_on_o, slew_mode_o, short_flag_o, enable_pin_pulldown_on_o;
  logic [5:0] threshold_sel_o;
  logic [15:0] step_down_target_reg_o;
  logic [1:0] d;
  int fails = 0, checks = 0, seed;

  // short counts keep the pin delay and timeout scenarios brief
  cepg_seq_top #(.DLY_STEP_CYC(4), .SS_TIMEOUT_CYC(20)) u_dut (.*);
  cepg_stage_model u_stage (.mclk_i(mclk_i), .on_i(conv_on_o), .short_i(sc),
    .done_o(soft_start_done_i));

  always #10 mclk_i = ~mclk_i;

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // main sequence, inputs change at the falling edge
  initial begin
    seed = 32'h4dc4b572;
    repeat (16) @(negedge mclk_i);
    sys_rst_i = 0;
    chk("pulldown", 3'h7, enable_pin_pulldown_on_o);
    active_low_reset_input_n_i = 1;
    repeat (8) @(negedge mclk_i);
    chk("load", 1, otp_load_o & io_enable_o);
    repeat (70) @(negedge mclk_i);
    chk("standby", {1'b1, 2'h2}, {watchdog_run_o, dev_state_o});
    step_down_on_bit_i = 2'h1;
    @(negedge mclk_i);
    chk("reg on", 1, conv_on_o[0]);
    step_down_on_bit_i = 2'h0;
    @(negedge mclk_i);
    chk("reg off", 0, conv_on_o[0]);
    // step-up follows each pin in turn, random delay codes
    for (int s = 1; s < 4; s++) begin
      d = 2'($random(seed));
      step_up_turn_on_delay_i = {2'h0, d};
      step_up_turn_off_delay_i = {2'h0, ~d};
      step_up_pin_select_i = 2'(s);
      step_up_on_bit_i = 1;
      @(negedge mclk_i);
      {enable_pin_three_i, enable_pin_two_i, enable_pin_one_i} = 3'h1 << (s - 1);
      repeat (4 * d + 1) @(negedge mclk_i);
      chk("up early", 0, conv_on_o[2]);
      repeat (3) @(negedge mclk_i);
      chk("up on", 1, conv_on_o[2]);
      {enable_pin_three_i, enable_pin_two_i, enable_pin_one_i} = 3'h0;
      repeat (4 * (3 - d) + 1) @(negedge mclk_i);
      chk("up late", 1, conv_on_o[2]);
      repeat (3) @(negedge mclk_i);
      chk("up off", 0, conv_on_o[2]);
    end
    // shorted step-down output trips after the timeout
    sc = 3'h2;
    step_down_on_bit_i = 2'h2;
    repeat (10) @(negedge mclk_i);
    chk("short early", 2'h1, {short_flag_o[1], conv_on_o[1]});
    repeat (16) @(negedge mclk_i);
    chk("short trip", 2'h2, {short_flag_o[1], conv_on_o[1]});
    step_down_on_bit_i = 2'h0;
    // live validity in both detection methods
    for (int i = 0; i < 16; i++) begin
      validity_method_sel_i = i[3];
      {below_ov_i, above_uv_i} = 6'($random(seed));
      @(negedge mclk_i);
      v = above_uv_i & (i[3] ? below_ov_i : 3'h7);
      chk("valid", v, {step_up_valid_state_o, step_down_valid_state_o});
    end
    validity_method_sel_i = 0;
    above_uv_i = 3'h0;
    good_flag_clr_i = 3'h7;
    repeat (2) @(negedge mclk_i);
    good_flag_clr_i = 3'h0;
    @(negedge mclk_i);
    above_uv_i = 3'h7;
    @(negedge mclk_i);
    chk("good", 3'h7, {step_up_good_flag_o, step_down_good_flag_o});
    // ramp of two codes at the fastest rate, 16 cycles per code
    step_down_voltage_code_i = 16'h0002;
    @(negedge mclk_i);
    chk("ramp start", 9'h100, {fixed_freq_o[0], step_down_target_reg_o[7:0]});
    repeat (39) @(negedge mclk_i);
    chk("ramp end", 9'h002, {fixed_freq_o[0], step_down_target_reg_o[7:0]});
    // clock returns in standby with the sync option on
    ext_sync_en_i = 1;
    ext_clk_present_i = 1;
    step_up_threshold_sel_i = 2'h1;
    step_down_threshold_sel_i = 4'h9;
    step_up_voltage_code_i = 2'h3;
    repeat (4) @(negedge mclk_i);
    chk("clock", 3'h7, {clk_flag_o, use_ext_clk_o, clk_det_en_o});
    chk("fields", 8'h67, {threshold_sel_o, step_up_level_o});
    pulldown_off_i = 3'h5;
    repeat (2) @(negedge mclk_i);
    chk("pulldown off", 3'h2, enable_pin_pulldown_on_o);
    complete_run();
  end
endmodule // testbench
